// *** design/rfw_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RFW_REGS_SVH
`define RFW_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RFW_OFF_CTRL        12'h000
`define RFW_OFF_STATUS      12'h004
`define RFW_OFF_OUT         12'h008
`define RFW_OFF_IN          12'h00C
`define RFW_OFF_ANA         12'h010
`define RFW_OFF_ENC         12'h014
`define RFW_OFF_WBITE       12'h018
`define RFW_OFF_SBITE       12'h01C
`define RFW_OFF_WCARD       12'h020
`define RFW_OFF_SCARD       12'h024
`define RFW_OFF_LINKIDX     12'h028
`define RFW_OFF_PDX         12'h02C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RFW_CTRL_MODE_LO    0
`define RFW_CTRL_FCLR       4
`define RFW_CTRL_ENC4X      5
`define RFW_ST_FAULT        0
`define RFW_ST_LOWV         1
`define RFW_ST_BITE         2
`define RFW_ST_SHORT        3
`define RFW_ST_HOT          4
`define RFW_ST_FLDLOSS      5

// ----------------------------------------------------------------------------
// reset values and encoder threshold code
// ----------------------------------------------------------------------------
`define RFW_BITE_DEF_MS     16'h0032
`define RFW_LINKIDX_DEF     8'h09
`define RFW_CARD_DEF        32'h0000_0000
`define RFW_THR_ENC_CODE    8'h12

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RFW_CLK_HZ          40000000
`define RFW_MS_PER_S        1000
`define RFW_CYC_PER_MS      (`RFW_CLK_HZ / `RFW_MS_PER_S)
`define RFW_BLINK_DIV       500

`endif

// *** design/rfw_pkg.sv ***
// types shared by the field i/o watchdog block
package rfw_pkg;
  // process data modes
  typedef enum logic [1:0] {
    RFW_MODE_IO   = 2'b00,
    RFW_MODE_ANA  = 2'b01,
    RFW_MODE_ANA2 = 2'b10,
    RFW_MODE_ENC  = 2'b11
  } rfw_mode_type;

  // driver chip feedback
  typedef struct packed {
    logic [15:0] short_trip;
    logic [1:0]  hot_warn;
  } rfw_drv_fb_type;

  // field supply sense
  typedef struct packed {
    logic upper_ok;
    logic lower_ok;
    logic logic_supply_jumper;
  } rfw_power_type;
endpackage : rfw_pkg

// *** design/rfw_top.sv ***
// field i/o processor: outputs, faults, watchdog, lamps, axi4-lite regs
`timescale 1ns/1ps
`include "rfw_regs.svh"

module rfw_top #(
  parameter int unsigned NUM_IN   = 32,
  parameter int unsigned NUM_OUT  = 16,
  parameter int unsigned CHIP_W   = 8,
  parameter int unsigned CYC_MS   = `RFW_CYC_PER_MS
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // field side
  input  wire logic [31:0]           field_in,
  input  wire logic [31:0]           field_ana,
  input  wire rfw_pkg::rfw_drv_fb_type drv_fb,
  input  wire rfw_pkg::rfw_power_type  power,
  input  wire logic                  setup_mode,
  output logic [15:0]                field_out,
  output logic [7:0]                 enc_threshold,
  output logic                       fault_lamp,
  output logic                       activity_lamp
);
  import rfw_pkg::*;

  // --------------------------------------------------------------------------
  // input synchronisers (two flops, first flop read only by second)
  // --------------------------------------------------------------------------
  logic [31:0] in_s1_r, in_s2_r;         // digital inputs
  logic [31:0] ana_s1_r, ana_s2_r;       // four 8-bit readings, inputs 0..3
  logic [17:0] fb_s1_r, fb_s2_r;         // driver feedback
  logic [2:0]  pw_s1_r, pw_s2_r;         // supply sense
  logic        su_s1_r, su_s2_r;         // setup jumper

  // sync chains sample through reset: a zeroed rail sense would read as
  // a missing rail at release and latch a false low-voltage fault
  always_ff @(posedge aclk) begin
    in_s1_r  <= field_in;
    in_s2_r  <= in_s1_r;
    ana_s1_r <= field_ana;
    ana_s2_r <= ana_s1_r;
    fb_s1_r  <= drv_fb;
    fb_s2_r  <= fb_s1_r;
    pw_s1_r  <= power;
    pw_s2_r  <= pw_s1_r;
    su_s1_r  <= setup_mode;
    su_s2_r  <= su_s1_r;
  end

  rfw_drv_fb_type fb;
  rfw_power_type  pw;
  assign fb = fb_s2_r;
  assign pw = pw_s2_r;

  // --------------------------------------------------------------------------
  // axi4-lite handshake
  // --------------------------------------------------------------------------
  logic        aw_got_r, w_got_r;        // address / data captured
  logic [11:0] aw_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        wr_go;                    // both halves present
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_r          <= 12'h000;
      wd_r          <= 32'h0000_0000;
      ws_r          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_r     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r    <= s_axi_wdata;
        ws_r    <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // address with word index past the pdx word answers slverr
        s_axi_bresp  <= (aw_r[11:2] > 10'(`RFW_OFF_PDX >> 2)) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte-lane merge of a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  logic we_ctrl, we_out, we_wbite, we_sbite, we_wcard, we_scard;
  logic we_link, we_pdx;
  // write decode
  always_comb begin
    we_ctrl  = 1'b0;
    we_out   = 1'b0;
    we_wbite = 1'b0;
    we_sbite = 1'b0;
    we_wcard = 1'b0;
    we_scard = 1'b0;
    we_link  = 1'b0;
    we_pdx   = 1'b0;
    if (!wr_go) begin
      we_ctrl = 1'b0;
    end else if (aw_r == `RFW_OFF_CTRL) begin
      we_ctrl = 1'b1;
    end else if (aw_r == `RFW_OFF_OUT) begin
      we_out = 1'b1;
    end else if (aw_r == `RFW_OFF_WBITE) begin
      we_wbite = 1'b1;
    end else if (aw_r == `RFW_OFF_SBITE) begin
      we_sbite = 1'b1;
    end else if (aw_r == `RFW_OFF_WCARD) begin
      we_wcard = 1'b1;
    end else if (aw_r == `RFW_OFF_SCARD) begin
      we_scard = 1'b1;
    end else if (aw_r == `RFW_OFF_LINKIDX) begin
      we_link = 1'b1;
    end else if (aw_r == `RFW_OFF_PDX) begin
      we_pdx = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // parameters: working and stored copies
  // --------------------------------------------------------------------------
  logic [15:0] working_bite_period_r;    // takes effect at once
  logic [15:0] stored_bite_period_r;     // read back only; never copied to working
  logic [31:0] working_card_id_r;
  logic [31:0] stored_card_id_r;
  logic [7:0]  stored_link_rate_index_r;
  logic [31:0] tmp_w;
  assign tmp_w = merge(32'h0000_0000, wd_r, ws_r);

  // stored values do not survive reset here; nothing copies them to working.
  // without real eeprom, both reset to the default.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      working_bite_period_r    <= `RFW_BITE_DEF_MS;
      stored_bite_period_r     <= `RFW_BITE_DEF_MS;
      working_card_id_r        <= `RFW_CARD_DEF;
      stored_card_id_r         <= `RFW_CARD_DEF;
      stored_link_rate_index_r <= `RFW_LINKIDX_DEF;
    end else begin
      if (we_wbite) begin
        working_bite_period_r <= 16'(merge({16'h0000, working_bite_period_r},
                                           wd_r, ws_r));
      end
      if (we_sbite) begin
        stored_bite_period_r <= 16'(merge({16'h0000, stored_bite_period_r},
                                          wd_r, ws_r));
      end
      if (we_wcard) begin
        working_card_id_r <= merge(working_card_id_r, wd_r, ws_r);
      end
      if (we_scard) begin
        stored_card_id_r <= merge(stored_card_id_r, wd_r, ws_r);
      end
      if (we_link && ws_r[0]) begin
        stored_link_rate_index_r <= tmp_w[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // mode / control
  // --------------------------------------------------------------------------
  rfw_mode_type mode_r;
  logic         enc4x_r;                 // 0 = 1x counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r  <= RFW_MODE_IO;
      enc4x_r <= 1'b0;
    end else if (we_ctrl && ws_r[0]) begin
      mode_r  <= rfw_mode_type'(wd_r[`RFW_CTRL_MODE_LO +: 2]);
      enc4x_r <= wd_r[`RFW_CTRL_ENC4X];
    end
  end

  // encoder thresholds forced to 2.5v code in encoder mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enc_threshold <= 8'h00;
    end else begin
      enc_threshold <= (mode_r == RFW_MODE_ENC) ? `RFW_THR_ENC_CODE
                                                : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------------------
  logic [15:0] ms_cnt_r;                 // ms elapsed since last pdx write
  logic [31:0] cyc_cnt_r;                // cycles within one ms
  logic        bite;
  logic        host_touch;               // process data exchange
  assign host_touch = we_pdx;
  assign bite = (working_bite_period_r != 16'h0000) &&
                (ms_cnt_r >= working_bite_period_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_r  <= 16'h0000;
      cyc_cnt_r <= 32'h0000_0000;
    end else if (host_touch) begin
      ms_cnt_r  <= 16'h0000;
      cyc_cnt_r <= 32'h0000_0000;
    end else if (cyc_cnt_r == 32'(CYC_MS - 1)) begin
      cyc_cnt_r <= 32'h0000_0000;
      if (ms_cnt_r != 16'hFFFF) begin
        ms_cnt_r <= ms_cnt_r + 16'h0001;
      end
    end else begin
      cyc_cnt_r <= cyc_cnt_r + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // faults: sticky, set wins over clear
  // --------------------------------------------------------------------------
  logic        fault_r, bite_f_r, lowv_r, short_f_r, hot_f_r;
  logic [15:0] short_lock_r;             // per-output latched disable
  logic [1:0]  hot_lock_r;               // per-chip latched disable
  logic        fclr;
  logic        lowv_now;
  assign fclr = we_ctrl && ws_r[0] && wd_r[`RFW_CTRL_FCLR];
  assign lowv_now = !(pw.upper_ok && pw.lower_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_r      <= 1'b1;
      bite_f_r     <= 1'b1;
      lowv_r       <= 1'b0;
      short_f_r    <= 1'b0;
      hot_f_r      <= 1'b0;
      short_lock_r <= 16'h0000;
      hot_lock_r   <= 2'b00;
    end else begin
      if (fclr) begin
        fault_r      <= 1'b0;
        bite_f_r     <= 1'b0;
        lowv_r       <= 1'b0;
        short_f_r    <= 1'b0;
        hot_f_r      <= 1'b0;
        short_lock_r <= 16'h0000;
        hot_lock_r   <= 2'b00;
      end
      if (bite) begin
        fault_r  <= 1'b1;
        bite_f_r <= 1'b1;
      end
      if (lowv_now) begin
        fault_r <= 1'b1;
        lowv_r  <= 1'b1;
      end
      if (|fb.short_trip) begin
        fault_r      <= 1'b1;
        short_f_r    <= 1'b1;
        short_lock_r <= (fclr ? 16'h0000 : short_lock_r) | fb.short_trip;
      end
      if (|fb.hot_warn) begin
        fault_r    <= 1'b1;
        hot_f_r    <= 1'b1;
        hot_lock_r <= (fclr ? 2'b00 : hot_lock_r) | fb.hot_warn;
      end
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  logic [15:0] out_req_r;                // host requested output image
  logic [15:0] chip_mask;                // hot chip expands to 8 outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_req_r <= 16'h0000;
    end else if (fault_r) begin
      out_req_r <= 16'h0000;
    end else if (we_out || we_pdx) begin
      out_req_r <= 16'(merge({16'h0000, out_req_r}, wd_r, ws_r));
    end
  end

  always_comb begin
    chip_mask = 16'h0000;
    for (int c = 0; c < NUM_OUT / CHIP_W; c++) begin
      chip_mask[c*CHIP_W +: CHIP_W] = {CHIP_W{hot_lock_r[c]}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_out <= 16'h0000;
    end else if (fault_r) begin
      field_out <= 16'h0000;
    end else begin
      field_out <= out_req_r & ~short_lock_r & ~chip_mask;
    end
  end

  // --------------------------------------------------------------------------
  // encoders: inputs 16/17 and 18/19 as quadrature pairs
  // --------------------------------------------------------------------------
  logic [1:0]  q_prev_r [2];
  logic [15:0] enc_cnt_r [2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int e = 0; e < 2; e++) begin
        q_prev_r[e]  <= 2'b00;
        enc_cnt_r[e] <= 16'h0000;
      end
    end else begin
      for (int e = 0; e < 2; e++) begin
        q_prev_r[e] <= in_s2_r[16 + 2*e +: 2];
        if (mode_r == RFW_MODE_ENC) begin
          // 1x: count on a rising edge only; 4x: every edge
          if (enc4x_r ? (q_prev_r[e][0] != in_s2_r[16 + 2*e]) ||
                        (q_prev_r[e][1] != in_s2_r[17 + 2*e])
                      : (!q_prev_r[e][0] && in_s2_r[16 + 2*e])) begin
            if ((q_prev_r[e][0] ^ in_s2_r[17 + 2*e]) == 1'b1 && enc4x_r) begin
              enc_cnt_r[e] <= enc_cnt_r[e] - 16'h0001;
            end else if (!enc4x_r && in_s2_r[17 + 2*e]) begin
              enc_cnt_r[e] <= enc_cnt_r[e] - 16'h0001;
            end else begin
              enc_cnt_r[e] <= enc_cnt_r[e] + 16'h0001;
            end
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // lamps: activity toggles every BLINK_DIV exchanges
  // --------------------------------------------------------------------------
  logic [9:0] blink_cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_r   <= 10'h000;
      activity_lamp <= 1'b0;
      fault_lamp    <= 1'b1;
    end else begin
      if (su_s2_r) begin
        activity_lamp <= 1'b1;
        fault_lamp    <= 1'b1;
      end else begin
        fault_lamp <= fault_r;
        if (fault_r) begin
          activity_lamp <= 1'b0;
        end else if (host_touch) begin
          if (blink_cnt_r == 10'(`RFW_BLINK_DIV - 1)) begin
            blink_cnt_r   <= 10'h000;
            activity_lamp <= !activity_lamp;
          end else begin
            blink_cnt_r <= blink_cnt_r + 10'h001;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_bad;
  // read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_bad = 1'b0;
    if (s_axi_araddr == `RFW_OFF_CTRL) begin
      rd_mux = {26'h0, enc4x_r, 3'b000, mode_r};
    end else if (s_axi_araddr == `RFW_OFF_STATUS) begin
      rd_mux = {26'h0, lowv_now && pw.logic_supply_jumper,
                hot_f_r, short_f_r, bite_f_r, lowv_r, fault_r};
    end else if (s_axi_araddr == `RFW_OFF_OUT) begin
      rd_mux = {16'h0000, field_out};
    end else if (s_axi_araddr == `RFW_OFF_IN) begin
      rd_mux = in_s2_r;
    end else if (s_axi_araddr == `RFW_OFF_ANA) begin
      rd_mux = (mode_r == RFW_MODE_ANA || mode_r == RFW_MODE_ANA2)
               ? ana_s2_r : 32'h0000_0000;
    end else if (s_axi_araddr == `RFW_OFF_ENC) begin
      rd_mux = {enc_cnt_r[1], enc_cnt_r[0]};
    end else if (s_axi_araddr == `RFW_OFF_WBITE) begin
      rd_mux = {16'h0000, working_bite_period_r};
    end else if (s_axi_araddr == `RFW_OFF_SBITE) begin
      rd_mux = {16'h0000, stored_bite_period_r};
    end else if (s_axi_araddr == `RFW_OFF_WCARD) begin
      rd_mux = working_card_id_r;
    end else if (s_axi_araddr == `RFW_OFF_SCARD) begin
      rd_mux = stored_card_id_r;
    end else if (s_axi_araddr == `RFW_OFF_LINKIDX) begin
      rd_mux = {24'h00_0000, stored_link_rate_index_r};
    end else if (s_axi_araddr == `RFW_OFF_PDX) begin
      rd_mux = in_s2_r;
    end else begin
      rd_bad = 1'b1;
    end
  end

  // one-cycle arready, data registered with it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_bad ? 2'b10 : 2'b00;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : rfw_top

// *** bench/rfw_top_props.sv ***
// checker for the field i/o watchdog block ports
`timescale 1ns/1ps
`include "rfw_regs.svh"
module rfw_top_props (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire rfw_pkg::rfw_drv_fb_type drv_fb,
  input wire rfw_pkg::rfw_power_type  power,
  input wire logic                    setup_mode,
  input wire logic [15:0]             field_out,
  input wire logic [7:0]              enc_threshold,
  input wire logic                    fault_lamp,
  input wire logic                    activity_lamp
);
  import rfw_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until taken
  AST_BV_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_RV_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  AST_ERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
    s_axi_rdata == 32'h0000_0000) else $error("error read carries data");
  AST_RST_STATE: assert property ($rose(aresetn) |->
    fault_lamp && !activity_lamp && field_out == 16'h0000)
    else $error("bad start");
  AST_SETUP_LAMPS: assert property (setup_mode [*4] |=>
    fault_lamp && activity_lamp) else $error("setup lamps off");
  AST_SHORT_OFF: assert property ($stable(drv_fb.short_trip) [*5] |->
    (field_out & drv_fb.short_trip) == 16'h0000) else $error("short on");
  AST_HOT_OFF: assert property (drv_fb.hot_warn[1] [*5] |->
    field_out[15:8] == 8'h00) else $error("hot chip drives");
  AST_RAIL_OFF: assert property (!power.upper_ok [*5] |->
    field_out == 16'h0000) else $error("outputs on without rail");
  AST_THR: assert property (enc_threshold == 8'h00 ||
    enc_threshold == `RFW_THR_ENC_CODE) else $error("bad threshold");
  COV_SETUP: cover property (setup_mode [*4] ##1 fault_lamp);
  COV_HOT: cover property (drv_fb.hot_warn[1] [*5]);
  COV_WR: cover property (s_axi_bvalid && s_axi_bready);
endmodule : rfw_top_props
bind rfw_top rfw_top_props u_props (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .drv_fb, .power, .setup_mode, .field_out, .enc_threshold, .fault_lamp,
  .activity_lamp);

// *** bench/rfw_host.sv ***
// host model: axi4-lite master that runs the process data exchanges
`timescale 1ns/1ps
module rfw_host (
  input  wire logic        aclk,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
  end
  // one write, halves released as each is taken; no fixed latency
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  // one read, data taken on the edge that shows rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rfw_host

// *** bench/rfw_top_tb.sv ***
// self-checking bench for the field i/o watchdog block
`timescale 1ns/1ps
`include "rfw_regs.svh"
module rfw_top_tb;
  import rfw_pkg::*;
  logic aclk = 0, aresetn = 0, setup_mode = 0, b;
  logic [31:0] field_in = 0, field_ana = 0, rv, v, s_axi_wdata, s_axi_rdata;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] rr, s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, fault_lamp, activity_lamp;
  logic [15:0] field_out;
  logic [7:0] enc_threshold;
  rfw_drv_fb_type drv_fb = '0;
  rfw_power_type power = 3'b110;
  int err_total = 0, comparisons = 0;
  always #12.5 aclk = ~aclk;
  rfw_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rfw_top #(.CYC_MS(10)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .field_in, .field_ana, .drv_fb, .power, .setup_mode,
    .field_out, .enc_threshold, .fault_lamp, .activity_lamp);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic r(logic [11:0] a); host.rd(a, rv, rr); endtask : r
  task automatic w(logic [11:0] a, logic [31:0] d); host.wr(a, d); endtask : w
  task automatic t(int n); repeat (n) @(posedge aclk); endtask : t
  // clear the latched faults by writing the ctrl fault-clear bit
  task automatic clr; w(`RFW_OFF_CTRL, 32'h0000_0010); endtask : clr
  initial begin
    t(60000);
    err_total++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h6073c9f9));
    t(12);
    aresetn <= 1;
    t(2);
    chk("lamps", 2'b10, {fault_lamp, activity_lamp});
    r(`RFW_OFF_STATUS); chk("st0", 32'h5, rv & 32'h7);
    r(`RFW_OFF_WBITE); chk("wbite", 32'h32, rv);
    r(`RFW_OFF_SBITE); chk("sbite", 32'h32, rv);
    r(`RFW_OFF_WCARD); chk("card", 32'h0, rv);
    r(`RFW_OFF_CTRL); chk("enc1x", 32'h0, rv & 32'h20);
    w(`RFW_OFF_PDX, 32'hffff); t(2); chk("ign", 32'h0, field_out);
    clr();
    repeat (4) begin
      v = $urandom & 32'hffff;
      w(`RFW_OFF_PDX, v); t(2); chk("out", v, field_out);
      field_in <= $urandom; t(4);
      r(`RFW_OFF_IN); chk("in", field_in, rv);
    end
    drv_fb.short_trip <= 16'h0004; t(6);
    r(`RFW_OFF_STATUS); chk("short", 32'h9, rv & 32'h9);
    drv_fb.short_trip <= 0; clr(); w(`RFW_OFF_PDX, 32'hffff);
    drv_fb.hot_warn <= 2'b10; t(6);
    chk("hot", 32'h0, field_out[15:8]);
    r(`RFW_OFF_STATUS); chk("hotst", 32'h11, rv & 32'h11);
    drv_fb.hot_warn <= 0; w(`RFW_OFF_WBITE, 3); w(`RFW_OFF_PDX, 1); clr();
    repeat (3) begin w(`RFW_OFF_PDX, 1); t(20); end
    r(`RFW_OFF_STATUS); chk("fed", 32'h0, rv & 32'h5);
    t(40); r(`RFW_OFF_STATUS); chk("bite", 32'h5, rv & 32'h5);
    chk("biteout", 32'h0, field_out);
    w(`RFW_OFF_WBITE, 0); clr(); t(200);
    r(`RFW_OFF_STATUS); chk("nobite", 32'h0, rv & 32'h1);
    w(`RFW_OFF_SBITE, 7); r(`RFW_OFF_WBITE); chk("keep", 0, rv);
    b = activity_lamp;
    repeat (500) w(`RFW_OFF_PDX, $urandom);
    chk("blink", {1'b0, ~b}, {fault_lamp, activity_lamp});
    for (int m = 0; m < 4; m++) begin
      field_ana <= $urandom; w(`RFW_OFF_CTRL, m); t(4);
      r(`RFW_OFF_ANA); chk("ana", m inside {1, 2} ? field_ana : 0, rv);
      chk("thr", m == 3 ? `RFW_THR_ENC_CODE : 0, enc_threshold);
    end
    field_in[17:16] <= 0; t(4); r(`RFW_OFF_ENC); v = rv + 1;
    field_in[16] <= 1; t(4); r(`RFW_OFF_ENC);
    chk("enc", v, rv);
    r(12'h100); chk("unmap", 32'h2, {rv[29:0], rr});
    w(12'h100, 0); chk("bresp", 2, s_axi_bresp);
    setup_mode <= 1; t(6); chk("setup", 2'b11, {fault_lamp, activity_lamp});
    setup_mode <= 0; power <= 3'b011; t(6); clr();
    r(`RFW_OFF_STATUS); chk("lowv", 32'h3, rv & 32'h3);
    power <= 3'b101; t(6);
    r(`RFW_OFF_STATUS); chk("loss", 32'h20, rv & 32'h20);
    wrap_up();
  end
endmodule : rfw_top_tb
